// ### logic/sbec_checker.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "sbec_consts.svh"
// Notes on behaviour
// - Uncorrectable address-cycle ECC error: ignore command and address/data buses one cycle.
// - Address-cycle error raises cache error exception and sets address error bit.
// - Address-cycle error pulses uncorrectable_err_n low one cycle.
// - Read data cycle with ECC error or quality bit marks that buffer entry.
// - Block forward with any marked flag: one cache error, load extent, data, index.
// - Word forward with marked flag raises a bus error exception.
// - Drive odd parity over the 3-bit state bus.
// - Agent sends odd response parity with valid strobe; device checks it.
// - Response parity error: ignore response one cycle, cache error, bit, pulse.
// - Parity error on word-read completion may hang; register flags response error.
// - ECC check only when command bit 0 comes with the valid strobe.
module sbec_checker #(
   parameter int ENTRY_W = 2,
   parameter int DWORD_W = 2,
   parameter int SECONDARY_INDEX_FIELD_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bus_valid_n,
   input wire logic [11:0] sys_command_bus,
   input wire logic [63:0] sys_addr_data_bus,
   input wire logic [7:0] addr_data_check_bus,
   input wire logic response_valid_n,
   input wire logic [4:0] response_bus,
   input wire logic response_parity,
   output logic uncorrectable_err_n,
   input wire logic [2:0] core_state,
   output logic [2:0] state_bus,
   output logic state_parity,
   input wire logic slave_state,
   input wire logic rd_pending,
   input wire logic [ENTRY_W-1:0] rd_entry,
   input wire logic [DWORD_W-1:0] rd_dword,
   input wire logic fwd_valid,
   input wire sbec_pkg::sbec_fwd_kind_type fwd_kind,
   input wire logic [ENTRY_W-1:0] fwd_entry,
   input wire logic [DWORD_W-1:0] fwd_dword,
   input wire logic [SECONDARY_INDEX_FIELD_W-1:0] fwd_secondary_index_field,
   input wire logic word_rd_wait,
   output logic ignore_cmd_ad,
   output logic ignore_resp,
   output logic cache_err_exc,
   output logic bus_err_exc,
   output logic irq
);

   localparam int ENTRIES = 1 << ENTRY_W;
   localparam int DWORDS = 1 << DWORD_W;

   // ****************************************
   // Check code
   // ****************************************

   // Column codes are all weight-3 then weight-5 bytes, so every
   // single-bit error gives an odd syndrome and doubles give even ones
   function automatic logic [7:0] ecc_gen(input logic [63:0] d);
      logic [7:0] c;
      int n;
      c = 8'h00;
      n = 0;
      for (int v = 0; v < 256; v++) begin
         if ($countones(v[7:0]) == `SBEC_ECC_W1 && n < 64) begin
            if (d[n]) begin
               c = c ^ v[7:0];
            end
            n++;
         end
      end
      for (int v = 0; v < 256; v++) begin
         if ($countones(v[7:0]) == `SBEC_ECC_W2 && n < 64) begin
            if (d[n]) begin
               c = c ^ v[7:0];
            end
            n++;
         end
      end
      return c;
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************

   sbec_pkg::sbec_pins_type pin_raw;
   sbec_pkg::sbec_pins_type pin_s1;
   sbec_pkg::sbec_pins_type pin_s2;

   assign pin_raw = '{valid_n: bus_valid_n, cmd: sys_command_bus,
                      ad: sys_addr_data_bus, chk: addr_data_check_bus,
                      rvalid_n: response_valid_n, resp: response_bus,
                      rpar: response_parity};

   // Idle level on reset so no false strobe appears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= '{valid_n: 1'b1, rvalid_n: 1'b1, default: '0};
         pin_s2 <= '{valid_n: 1'b1, rvalid_n: 1'b1, default: '0};
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   // ****************************************
   // Error detection
   // ****************************************

   logic [1:0] ctrl;
   logic [7:0] syndrome;
   logic bus_on;
   logic chk_on;
   logic unc;
   logic addr_err;
   logic data_mark;
   logic resp_on;
   logic resp_err;
   logic [DWORDS-1:0] flags [ENTRIES];
   logic blk_err;
   logic wrd_err;

   // The ignore flop masks the cycle right after an error
   assign bus_on = !pin_s2.valid_n && slave_state && !ignore_cmd_ad;
   assign chk_on = bus_on && pin_s2.cmd[`SBEC_CMD_CHKEN] && ctrl[`SBEC_CTRL_ECC];
   assign syndrome = ecc_gen(pin_s2.ad) ^ pin_s2.chk;
   // Even nonzero syndrome means two flipped bits
   assign unc = chk_on && (syndrome != 8'h00) && !(^syndrome);
   assign addr_err = unc && !pin_s2.cmd[`SBEC_CMD_DATA];
   assign data_mark = bus_on && pin_s2.cmd[`SBEC_CMD_DATA] && rd_pending
                      && (unc || pin_s2.cmd[`SBEC_CMD_DQ]);

   // Odd parity: the six bits together must xor to one
   assign resp_on = !pin_s2.rvalid_n && !ignore_resp && ctrl[`SBEC_CTRL_RPAR];
   assign resp_err = resp_on && !(^{pin_s2.resp, pin_s2.rpar});

   assign blk_err = fwd_valid && fwd_kind == sbec_pkg::SBEC_FWD_BLOCK
                    && (|flags[fwd_entry]);
   assign wrd_err = fwd_valid && fwd_kind == sbec_pkg::SBEC_FWD_WORD
                    && flags[fwd_entry][fwd_dword];

   // ****************************************
   // Incoming buffer flags
   // ****************************************

   // A forward drains the entry; a new mark in that cycle still wins
   for (genvar g = 0; g < ENTRIES * DWORDS; g++) begin : g_flag
      localparam int E = g / DWORDS;
      localparam int D = g % DWORDS;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            flags[E][D] <= 1'b0;
         end else if (data_mark && rd_entry == ENTRY_W'(E)
                      && rd_dword == DWORD_W'(D)) begin
            flags[E][D] <= 1'b1;
         end else if (fwd_valid && fwd_entry == ENTRY_W'(E)) begin
            flags[E][D] <= 1'b0;
         end
      end
   end

   // ****************************************
   // Pin side outputs
   // ****************************************

   // One-cycle ignore, notification and exception pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ignore_cmd_ad <= 1'b0;
         ignore_resp <= 1'b0;
         uncorrectable_err_n <= 1'b1;
         cache_err_exc <= 1'b0;
         bus_err_exc <= 1'b0;
      end else begin
         ignore_cmd_ad <= addr_err;
         ignore_resp <= resp_err;
         uncorrectable_err_n <= !(addr_err || resp_err);
         cache_err_exc <= addr_err || resp_err || blk_err;
         bus_err_exc <= wrd_err;
      end
   end

   // State bus with its parity, both from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_bus <= 3'h0;
         state_parity <= 1'b1;
      end else begin
         state_bus <= core_state;
         state_parity <= !(^core_state);
      end
   end

   // ****************************************
   // Register file
   // ****************************************

   logic acc;
   logic wr;
   logic [31:0] cache_err;
   logic [`SBEC_ST_W-1:0] status;
   logic [`SBEC_ST_W-1:0] irq_en;
   logic [`SBEC_ST_W-1:0] events;
   logic [`SBEC_ST_W-1:0] clr;
   logic ce_clr;
   logic mapped;
   logic [31:0] next_prdata;

   // Completing edge of an access: one wait state per transfer
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign clr = (wr && paddr == `SBEC_OFF_CLEAR) ? pwdata[`SBEC_ST_W-1:0] : '0;
   assign ce_clr = wr && paddr == `SBEC_OFF_CACHE_ERR;

   assign events[`SBEC_ST_ADDR] = addr_err;
   assign events[`SBEC_ST_RESP] = resp_err;
   assign events[`SBEC_ST_CACHE] = addr_err || resp_err || blk_err;
   assign events[`SBEC_ST_BUS] = wrd_err;

   // Read mux and decode; unmapped offsets read zero with an error
   always_comb begin
      mapped = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
         `SBEC_OFF_STATUS: next_prdata[`SBEC_ST_W-1:0] = status;
         `SBEC_OFF_ENABLE: next_prdata[`SBEC_ST_W-1:0] = irq_en;
         `SBEC_OFF_CLEAR: next_prdata = 32'h0000_0000;
         `SBEC_OFF_CACHE_ERR: next_prdata = cache_err;
         `SBEC_OFF_CTRL: next_prdata[1:0] = ctrl;
         default: mapped = 1'b0;
      endcase
   end

   // APB handshake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= !mapped;
         end
      end
   end

   // Writable control and interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SBEC_CTRL_RESET;
         irq_en <= '0;
      end else if (wr && paddr == `SBEC_OFF_CTRL) begin
         ctrl <= pwdata[1:0];
      end else if (wr && paddr == `SBEC_OFF_ENABLE) begin
         irq_en <= pwdata[`SBEC_ST_W-1:0];
      end
   end

   // Sticky status: a new event outranks the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         irq <= 1'b0;
      end else begin
         status <= (status & ~clr) | events;
         irq <= |(((status & ~clr) | events) & irq_en);
      end
   end

   // Cache error register; held until software writes it or presetn clears it,
   // so a stalled word read can still be diagnosed before the next reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cache_err <= 32'h0000_0000;
      end else begin
         if (ce_clr) begin
            cache_err <= 32'h0000_0000;
         end
         if (addr_err) begin
            cache_err[`SBEC_CE_SA] <= 1'b1;
         end
         if (resp_err) begin
            cache_err[`SBEC_CE_SR] <= 1'b1;
         end
         if (resp_err && word_rd_wait) begin
            cache_err[`SBEC_CE_HANG] <= 1'b1;
         end
         if (blk_err) begin
            cache_err[`SBEC_CE_EE] <= 1'b1;
            cache_err[`SBEC_CE_D] <= 1'b1;
            cache_err[`SBEC_CE_SECONDARY_INDEX_FIELD_LSB +: SECONDARY_INDEX_FIELD_W] <= fwd_secondary_index_field;
         end
      end
   end

endmodule

// ### logic/sbec_consts.svh
`ifndef SBEC_CONSTS_SVH
`define SBEC_CONSTS_SVH

// Register byte offsets
`define SBEC_OFF_STATUS 12'h000
`define SBEC_OFF_ENABLE 12'h004
`define SBEC_OFF_CLEAR 12'h008
`define SBEC_OFF_CACHE_ERR 12'h00c
`define SBEC_OFF_CTRL 12'h010

// Status, enable and clear bit positions
`define SBEC_ST_ADDR 0
`define SBEC_ST_RESP 1
`define SBEC_ST_CACHE 2
`define SBEC_ST_BUS 3
`define SBEC_ST_W 4

// Cache error register fields
`define SBEC_CE_SA 0
`define SBEC_CE_SR 1
`define SBEC_CE_EE 2
`define SBEC_CE_D 3
`define SBEC_CE_HANG 4
`define SBEC_CE_SECONDARY_INDEX_FIELD_LSB 8

// Control register bits and reset value
`define SBEC_CTRL_ECC 0
`define SBEC_CTRL_RPAR 1
`define SBEC_CTRL_RESET 2'h3

// Command bus bit positions
`define SBEC_CMD_CHKEN 0
`define SBEC_CMD_DQ 5
`define SBEC_CMD_DATA 11

// Check code build: weight-3 columns first, then weight-5
`define SBEC_ECC_W1 3
`define SBEC_ECC_W2 5

`endif

// ### logic/sbec_pkg.sv
package sbec_pkg;

   // Pin group sampled from the cluster bus
   typedef struct packed {
      logic valid_n;
      logic [11:0] cmd;
      logic [63:0] ad;
      logic [7:0] chk;
      logic rvalid_n;
      logic [4:0] resp;
      logic rpar;
   } sbec_pins_type;

   // Kind of forwarded data
   typedef enum logic {
      SBEC_FWD_BLOCK = 1'b0,
      SBEC_FWD_WORD = 1'b1
   } sbec_fwd_kind_type;

endpackage

// ### dv/sbec_checker_properties.sv
`timescale 1ns/1ps
module sbec_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic uncorrectable_err_n,
   input wire logic [2:0] state_bus,
   input wire logic state_parity,
   input wire logic response_valid_n,
   input wire logic [4:0] response_bus,
   input wire logic response_parity,
   input wire logic ignore_cmd_ad,
   input wire logic ignore_resp,
   input wire logic cache_err_exc,
   input wire logic bus_err_exc,
   input wire logic fwd_valid,
   input wire sbec_pkg::sbec_fwd_kind_type fwd_kind
);
   // ****
   // Properties
   // ****
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pulses last one cycle and always come with their companions
   uerr_pulse_a: assert property (!uncorrectable_err_n |=> uncorrectable_err_n) else $error("uerr long");
   uerr_cause_a: assert property (!uncorrectable_err_n |-> cache_err_exc && (ignore_cmd_ad || ignore_resp))
      else $error("uerr alone");
   ign_once_a: assert property (ignore_cmd_ad |=> !ignore_cmd_ad) else $error("ignore long");
   state_par_a: assert property (state_parity == !(^state_bus)) else $error("state parity");
   // Pins reach the outputs three edges later
   resp_err_a: assert property (!response_valid_n && !(^{response_bus, response_parity}) |-> ##3 ignore_resp)
      else $error("parity missed");
   resp_ign_a: assert property (ignore_resp |-> !uncorrectable_err_n && !$past(response_valid_n, 3))
      else $error("bad ignore");
   bus_err_a: assert property (bus_err_exc |-> $past(fwd_valid) && $past(fwd_kind) == sbec_pkg::SBEC_FWD_WORD)
      else $error("bus err");
   blk_quiet_a: assert property (fwd_valid && fwd_kind == sbec_pkg::SBEC_FWD_BLOCK |=> !bus_err_exc)
      else $error("block bus err");
   cover property (ignore_cmd_ad && !uncorrectable_err_n);
   cover property (ignore_resp);
   cover property (bus_err_exc);
endmodule

// ### dv/sbec_agent.sv
`timescale 1ns/1ps
module sbec_agent (
   input wire logic pclk,
   output logic bus_valid_n = 1'b1,
   output logic [11:0] sys_command_bus = 12'h000,
   output logic [63:0] sys_addr_data_bus = 64'h0,
   output logic [7:0] addr_data_check_bus = 8'h00,
   output logic response_valid_n = 1'b1,
   output logic [4:0] response_bus = 5'h00,
   output logic response_parity = 1'b0
);
   // ****
   // Check code and cycles
   // ****
   // Weight-3 columns then weight-5, so any double flip gives an even syndrome
   function automatic logic [7:0] ecc(input logic [63:0] d);
      logic [7:0] c;
      int k;
      c = 8'h00;
      k = 0;
      for (int w = 3; w <= 5; w += 2)
         for (int v = 0; v < 256; v++)
            if ($countones(v[7:0]) == w && k < 64) begin
               if (d[k]) c ^= v[7:0];
               k++;
            end
      return c;
   endfunction
   // One strobed cycle; check code from clean data, flips land on the wire
   task automatic addr_cyc(input logic [63:0] d, input logic [11:0] c, input logic [63:0] f);
      @(posedge pclk);
      bus_valid_n <= 1'b0;
      sys_command_bus <= c;
      sys_addr_data_bus <= d ^ f;
      addr_data_check_bus <= ecc(d);
      @(posedge pclk);
      bus_valid_n <= 1'b1;
      sys_command_bus <= ~c; // Released lines never keep the old value
      sys_addr_data_bus <= ~(d ^ f);
      addr_data_check_bus <= ~ecc(d);
   endtask
   // Bad parity only when the bench asks for it
   task automatic resp(input logic [4:0] r, input logic bad);
      @(posedge pclk);
      response_valid_n <= 1'b0;
      response_bus <= r;
      response_parity <= ~^r ^ bad;
      @(posedge pclk);
      response_valid_n <= 1'b1;
      response_bus <= ~r;
      response_parity <= ^r;
   endtask
endmodule

// ### dv/test_sysbus_error_checker.sv
`timescale 1ns/1ps
`include "sbec_consts.svh"
module test_sysbus_error_checker;
   // ****
   // Signals
   // ****
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [11:0] paddr = 12'h000, sys_command_bus;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic bus_valid_n, response_valid_n, response_parity, uncorrectable_err_n, state_parity;
   logic [63:0] sys_addr_data_bus, d;
   logic [7:0] addr_data_check_bus;
   logic [4:0] response_bus;
   logic [2:0] core_state = 3'h0, state_bus;
   logic slave_state = 1'b1, rd_pending = 1'b0, fwd_valid = 1'b0, word_rd_wait = 1'b0;
   logic [1:0] rd_entry = 2'h0, rd_dword = 2'h0, fwd_entry = 2'h0, fwd_dword = 2'h0;
   logic [15:0] fwd_secondary_index_field = 16'h0;
   sbec_pkg::sbec_fwd_kind_type fwd_kind = sbec_pkg::SBEC_FWD_BLOCK;
   logic ignore_cmd_ad, ignore_resp, cache_err_exc, bus_err_exc, irq;
   int num_errors = 0, n_tests = 0, seed = 32'hbddd;
   sbec_checker dut (.*);
   sbec_agent agt (.*);
   // Free-running clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ****
   // Tasks
   // ****
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Odd parity bit expected beside a state value
   function automatic logic odd_par(input logic [2:0] s);
      return ~^s;
   endfunction
   // Ends just past an edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   // Idle cycle after each transfer keeps psel from toggling twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd = 32'h0);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         close_out;
      end
      tick(1);
   endtask
   // Data reply that marks one incoming entry
   task automatic mark(input logic [1:0] en, input logic [11:0] c, input logic [63:0] f);
      rd_pending <= 1'b1;
      rd_entry <= en;
      rd_dword <= en; // Spread marks over the doublewords
      agt.addr_cyc(d, c, f);
      tick(2);
      rd_pending <= 1'b0;
   endtask
   // Result pulses stand one cycle, so the caller compares right after return
   task automatic fwd(input sbec_pkg::sbec_fwd_kind_type k, input logic [1:0] en, input logic [15:0] s);
      @(posedge pclk);
      fwd_valid <= 1'b1;
      fwd_kind <= k;
      fwd_entry <= en;
      fwd_dword <= en;
      fwd_secondary_index_field <= s;
      @(posedge pclk);
      fwd_valid <= 1'b0;
      tick(0);
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      chk("uerr_n", uncorrectable_err_n, 1'b1);
      apb(1'b0, `SBEC_OFF_CTRL);
      chk("ctrl", q, `SBEC_CTRL_RESET);
      apb(1'b1, `SBEC_OFF_ENABLE, 32'hf);
      apb(1'b0, 12'h020);
      chk("slverr", e, 1'b1);
      // Clean traffic must stay silent
      for (int i = 0; i < 8; i++) begin
         d = {$random(seed), $random(seed)};
         core_state <= d[2:0];
         agt.addr_cyc(d, 12'h001, 64'h0);
         tick(2);
         chk("state", state_bus, d[2:0]);
         chk("state_par", state_parity, odd_par(d[2:0]));
         chk("clean ecc", uncorrectable_err_n, 1'b1);
         agt.resp(d[12:8], 1'b0);
         tick(2);
         chk("clean par", ignore_resp, 1'b0);
      end
      agt.addr_cyc(d, 12'h000, 64'h3);
      tick(2);
      chk("ecc off", uncorrectable_err_n, 1'b1);
      agt.addr_cyc(d, 12'h001, 64'h3);
      tick(2);
      chk("uerr", uncorrectable_err_n, 1'b0);
      chk("ign", ignore_cmd_ad, 1'b1);
      chk("cexc", cache_err_exc, 1'b1);
      tick(1);
      chk("ign end", ignore_cmd_ad, 1'b0);
      chk("irq", irq, 1'b1);
      apb(1'b0, `SBEC_OFF_STATUS);
      chk("status", q, 32'h5);
      apb(1'b0, `SBEC_OFF_CACHE_ERR);
      chk("sa", q, 32'h1);
      apb(1'b1, `SBEC_OFF_CLEAR, 32'hf);
      apb(1'b1, `SBEC_OFF_CACHE_ERR);
      chk("irq clr", irq, 1'b0);
      // Parity error while a word read waits for completion
      word_rd_wait <= 1'b1;
      agt.resp(d[4:0], 1'b1);
      tick(2);
      chk("ign resp", ignore_resp, 1'b1);
      chk("uerr resp", uncorrectable_err_n, 1'b0);
      word_rd_wait <= 1'b0;
      apb(1'b0, `SBEC_OFF_CACHE_ERR);
      chk("hang", q, 32'h12);
      apb(1'b1, `SBEC_OFF_CACHE_ERR);
      mark(2'h2, 12'h820, 64'h0);
      fwd(sbec_pkg::SBEC_FWD_WORD, 2'h1, 16'h0);
      chk("clean word", bus_err_exc, 1'b0);
      fwd(sbec_pkg::SBEC_FWD_WORD, 2'h2, 16'h0);
      chk("bus err", bus_err_exc, 1'b1);
      fwd(sbec_pkg::SBEC_FWD_WORD, 2'h2, 16'h0);
      chk("flag gone", bus_err_exc, 1'b0);
      mark(2'h3, 12'h801, 64'h3);
      fwd(sbec_pkg::SBEC_FWD_BLOCK, 2'h3, d[31:16]);
      chk("blk cexc", cache_err_exc, 1'b1);
      apb(1'b0, `SBEC_OFF_CACHE_ERR);
      chk("ee", q, {8'h0, d[31:16], 8'h0c});
      close_out;
   end
endmodule
bind sbec_checker sbec_props props (.*);
